/* File: verilog/nand_ctrl_params.svh */
/*
  Constants for the NAND status, identification, erase and reset host
  controller: command codes, field positions and bus timing counts.
  Assumes a 250 MHz system clock; the including file uses them as-is.
*/
`ifndef NAND_CTRL_PARAMS_SVH
`define NAND_CTRL_PARAMS_SVH

`define CLK_PERIOD_NS    4
// command codes
`define CMD_ERASE_SETUP  8'h60
`define CMD_ERASE_START  8'hD0
`define CMD_STATUS       8'h70
`define CMD_DSTATUS      8'h71
`define CMD_RESET        8'hFF
`define CMD_ID_READ      8'h90
`define ID_ADDR_BYTE     8'h00
`define ID_LEN           5
// status byte bit positions (data_line_1 is bit 0)
`define ST_FAIL_CUR      0
`define ST_FAIL_PREV     1
`define ST_D0_FAIL1      1
`define ST_D1_FAIL1      2
`define ST_D0_FAIL2      3
`define ST_D1_FAIL2      4
`define ST_PAGE_RDY      5
`define ST_CACHE_RDY     6
`define ST_NOT_WP        7
// identification field positions
`define ID3_CHIPS_LSB    0
`define ID3_CELL_LSB     2
`define ID4_PAGE_LSB     0
`define ID4_BLOCK_LSB    4
`define ID4_WIDTH_BIT    6
`define ID5_DIST_LSB     2
// row address layout: page in low bits, block above it
`define ROW_PAGE_BITS    6
`define ROW_W_DEFAULT    18
// strobe timing in ns, turned into cycles by rounding up
`define T_WE_LOW_NS      12
`define T_WE_HIGH_NS     10
`define T_RE_LOW_NS      20
`define T_RE_HIGH_NS     10
`define T_WB_NS          100
`define CYC_UP(ns)       (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: verilog/nand_ctrl_pkg.sv */
/*
  Types for the NAND host controller: user operations, sequence items and
  the decoded status and identification results.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package nand_ctrl_pkg;

  typedef enum logic [2:0] {
    OP_RESET   = 3'h0,
    OP_STATUS  = 3'h1,
    OP_DSTATUS = 3'h2,
    OP_ID      = 3'h3,
    OP_ERASE   = 3'h4,
    OP_MERASE  = 3'h5
  } op_type;

  typedef enum logic [2:0] {
    K_CMD  = 3'h0,
    K_ADDR = 3'h1,
    K_READ = 3'h2,
    K_WAIT = 3'h3,
    K_END  = 3'h4
  } kind_type;

  typedef struct packed {
    kind_type   kind;
    logic [7:0] data;
  } item_type;

  typedef struct packed {
    logic [7:0] raw;
    logic       fail_cur;
    logic       fail_prev;
    logic       pass_fail_valid;
    logic       page_ready;
    logic       cache_ready;
    logic       not_protected;
    logic       ready_mismatch;
    logic [3:0] district_fail;
  } status_info_type;

  typedef struct packed {
    logic [7:0] maker;
    logic [7:0] device;
    logic [3:0] chip_count;
    logic [4:0] cell_levels;
    logic [3:0] page_kb;
    logic [9:0] block_kb;
    logic       x16;
    logic [3:0] districts;
  } id_info_type;

endpackage

`default_nettype wire

/* File: verilog/nand_status_id_reset_control.sv */
/*
  Host-side NAND controller for reset, status read, district status read,
  identification read and single or two-district block erase.
  Assumes one NAND device on the pins, an open-drain ready_busy_n pulled
  up outside, and a user that waits for cmd_ready_o before a new order.
*/
// Operation
// - one block per district in multi erase
// - end erase with start, abort with reset
// - status byte on each read strobe
// - during power-on only reset or status
// - never send undefined command codes
// - while busy only 70h, 71h, reset
// - shared busy wire: use status reads
`default_nettype none
`include "nand_ctrl_params.svh"

module nand_status_id_reset_control
  import nand_ctrl_pkg::*;
#(
  parameter int ROW_W = `ROW_W_DEFAULT
) (
  input  wire logic            sys_clk_i,
  input  wire logic            sys_rst_i,
  input  wire logic            cmd_valid_i,
  input  wire op_type          cmd_op_i,
  input  wire logic [ROW_W-1:0] row_a_i,
  input  wire logic [ROW_W-1:0] row_b_i,
  input  wire logic            erase_enable_i,
  output logic                 cmd_ready_o,
  output logic                 done_o,
  output logic                 refused_o,
  output logic                 device_ready_o,
  output status_info_type      status_o,
  output id_info_type          id_o,
  output logic                 ce_n_o,
  output logic                 cle_o,
  output logic                 ale_o,
  output logic                 we_n_o,
  output logic                 read_strobe_n_o,
  output logic                 wp_n_o,
  input  wire logic            ready_busy_n_i,
  input  wire logic [7:0]      dq_i,
  output logic [7:0]           dq_o,
  output logic                 dq_oe_o
);

  if (ROW_W <= `ROW_PAGE_BITS + 1 || ROW_W > 24)
    $error("ROW_W must leave a block field and fit three address cycles");

  localparam logic [7:0] WE_LO = 8'(`CYC_UP(`T_WE_LOW_NS));
  localparam logic [7:0] WE_HI = 8'(`CYC_UP(`T_WE_HIGH_NS));
  localparam logic [7:0] RE_LO = 8'(`CYC_UP(`T_RE_LOW_NS));
  localparam logic [7:0] RE_HI = 8'(`CYC_UP(`T_RE_HIGH_NS));
  localparam logic [7:0] WB_C  = 8'(`CYC_UP(`T_WB_NS));

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ISSUE = 6'h02,
    ST_LOW   = 6'h04,
    ST_HIGH  = 6'h08,
    ST_WAITB = 6'h10,
    ST_WAITR = 6'h20
  } state_type;

  function automatic logic [7:0] addr_byte(input logic [ROW_W-1:0] row,
                                           input logic [1:0] idx);
    logic [23:0] w;
    w = 24'(row);
    addr_byte = w[8*idx +: 8];
  endfunction

  // every code sent comes from this table, so nothing undefined leaves
  function automatic item_type seq_item(input op_type op,
                                        input logic [3:0] st,
                                        input logic [ROW_W-1:0] ra,
                                        input logic [ROW_W-1:0] rb);
    seq_item = '{K_END, 8'h00};
    unique case (op)
      OP_RESET:
        if (st == 4'h0) seq_item = '{K_CMD, `CMD_RESET};
        else if (st == 4'h1) seq_item = '{K_WAIT, 8'h00};
      OP_STATUS, OP_DSTATUS:
        if (st == 4'h0)
          seq_item = '{K_CMD, (op == OP_STATUS) ? `CMD_STATUS
                                                : `CMD_DSTATUS};
        else if (st == 4'h1) seq_item = '{K_READ, 8'h00};
      OP_ID:
        if (st == 4'h0) seq_item = '{K_CMD, `CMD_ID_READ};
        else if (st == 4'h1) seq_item = '{K_ADDR, `ID_ADDR_BYTE};
        else if (st < 4'(2 + `ID_LEN)) seq_item = '{K_READ, 8'h00};
      OP_ERASE:
        if (st == 4'h0) seq_item = '{K_CMD, `CMD_ERASE_SETUP};
        else if (st <= 4'h3) seq_item = '{K_ADDR, addr_byte(ra, 2'(st - 4'h1))};
        else if (st == 4'h4) seq_item = '{K_CMD, `CMD_ERASE_START};
        else if (st == 4'h5) seq_item = '{K_WAIT, 8'h00};
      OP_MERASE:
        if (st == 4'h0 || st == 4'h4) seq_item = '{K_CMD, `CMD_ERASE_SETUP};
        else if (st <= 4'h3) seq_item = '{K_ADDR, addr_byte(ra, 2'(st - 4'h1))};
        else if (st <= 4'h7) seq_item = '{K_ADDR, addr_byte(rb, 2'(st - 4'h5))};
        else if (st == 4'h8) seq_item = '{K_CMD, `CMD_ERASE_START};
        else if (st == 4'h9) seq_item = '{K_WAIT, 8'h00};
      default: seq_item = '{K_END, 8'h00};
    endcase
  endfunction

  state_type             state_r, state_nxt;
  op_type                op_r, op_nxt;
  logic [ROW_W-1:0]      ra_r, ra_nxt, rb_r, rb_nxt;
  logic [3:0]            step_r, step_nxt;
  logic [7:0]            cnt_r, cnt_nxt;
  logic                  rd_r, rd_nxt;
  logic [2:0]            ridx_r, ridx_nxt;
  logic [7:0]            rbuf_r [`ID_LEN];
  logic [7:0]            rbuf_nxt [`ID_LEN];
  logic [2:0]            rb_s_r, rb_s_nxt;
  logic [7:0]            dq_s1_r, dq_s2_r, dq_s3_r;
  logic                  rdy_r, rdy_nxt, init_r, init_nxt, pe_r, pe_nxt;
  logic                  cmd_ready_nxt, done_nxt, refused_nxt;
  status_info_type       status_nxt;
  id_info_type           id_nxt;
  logic                  ce_n_nxt, cle_nxt, ale_nxt, we_n_nxt, re_n_nxt;
  logic                  wp_n_nxt, dq_oe_nxt;
  logic [7:0]            dq_nxt;
  item_type              item;
  logic                  allowed, dist_ok;
  logic [7:0]            sb;

  always_comb
  begin
    state_nxt = state_r;    op_nxt = op_r;       ra_nxt = ra_r;
    rb_nxt = rb_r;          step_nxt = step_r;   cnt_nxt = cnt_r;
    rd_nxt = rd_r;          ridx_nxt = ridx_r;   rbuf_nxt = rbuf_r;
    init_nxt = init_r;      pe_nxt = pe_r;       status_nxt = status_o;
    id_nxt = id_o;          done_nxt = 1'b0;     refused_nxt = 1'b0;
    ce_n_nxt = ce_n_o;      cle_nxt = cle_o;     ale_nxt = ale_o;
    we_n_nxt = we_n_o;      re_n_nxt = read_strobe_n_o;
    dq_nxt = dq_o;          dq_oe_nxt = dq_oe_o;
    wp_n_nxt = erase_enable_i;
    rb_s_nxt = {rb_s_r[1:0], ready_busy_n_i};
    // a busy level counts only once the last two stages agree
    rdy_nxt = (rb_s_r[1] == rb_s_r[2]) ? rb_s_r[2] : rdy_r;
    if (rdy_r) init_nxt = 1'b1;
    item = seq_item(op_r, step_r, ra_r, rb_r);
    sb = rbuf_r[0];
    // district is the block's low bit; both blocks from one half
    dist_ok = (row_a_i[`ROW_PAGE_BITS] != row_b_i[`ROW_PAGE_BITS]) &&
              (row_a_i[ROW_W-1] == row_b_i[ROW_W-1]);
    unique case (cmd_op_i)
      OP_RESET, OP_STATUS: allowed = 1'b1;
      OP_DSTATUS:          allowed = init_r;
      OP_MERASE:           allowed = init_r && rdy_r && dist_ok;
      OP_ID, OP_ERASE:     allowed = init_r && rdy_r;
      default:             allowed = 1'b0;
    endcase

    unique case (state_r)
      ST_IDLE:
        if (cmd_valid_i)
        begin
          if (allowed)
          begin
            op_nxt = cmd_op_i;
            ra_nxt = row_a_i;
            rb_nxt = row_b_i;
            step_nxt = 4'h0;
            ridx_nxt = 3'h0;
            ce_n_nxt = 1'b0;
            state_nxt = ST_ISSUE;
          end
          else
          begin
            done_nxt = 1'b1;
            refused_nxt = 1'b1;
          end
        end
      ST_ISSUE:
        unique case (item.kind)
          K_CMD, K_ADDR:
          begin
            cle_nxt = (item.kind == K_CMD);
            ale_nxt = (item.kind == K_ADDR);
            dq_nxt = item.data;
            dq_oe_nxt = 1'b1;
            we_n_nxt = 1'b0;
            rd_nxt = 1'b0;
            cnt_nxt = WE_LO - 8'h01;
            state_nxt = ST_LOW;
          end
          K_READ:
          begin
            re_n_nxt = 1'b0;
            dq_oe_nxt = 1'b0;
            rd_nxt = 1'b1;
            cnt_nxt = RE_LO - 8'h01;
            state_nxt = ST_LOW;
          end
          K_WAIT:
          begin
            cnt_nxt = WB_C - 8'h01;
            state_nxt = ST_WAITB;
          end
          default:
          begin
            ce_n_nxt = 1'b1;
            done_nxt = 1'b1;
            state_nxt = ST_IDLE;
            if (op_r == OP_ERASE || op_r == OP_MERASE) pe_nxt = 1'b1;
            if (op_r == OP_RESET) pe_nxt = 1'b0;
            if (op_r == OP_STATUS || op_r == OP_DSTATUS)
            begin
              status_nxt.raw = sb;
              status_nxt.fail_cur = sb[`ST_FAIL_CUR];
              status_nxt.fail_prev = sb[`ST_FAIL_PREV];
              status_nxt.page_ready = sb[`ST_PAGE_RDY];
              status_nxt.cache_ready = sb[`ST_CACHE_RDY];
              status_nxt.not_protected = sb[`ST_NOT_WP];
              // only erase results are judged; a reset leaves it invalid
              status_nxt.pass_fail_valid = pe_r && sb[`ST_PAGE_RDY];
              // no cached command is ever issued, so they must agree
              status_nxt.ready_mismatch =
                sb[`ST_PAGE_RDY] ^ sb[`ST_CACHE_RDY];
              status_nxt.district_fail = (op_r == OP_DSTATUS) ?
                {sb[`ST_D1_FAIL2], sb[`ST_D0_FAIL2],
                 sb[`ST_D1_FAIL1], sb[`ST_D0_FAIL1]} : 4'h0;
            end
            if (op_r == OP_ID)
            begin
              id_nxt.maker = rbuf_r[0];
              id_nxt.device = rbuf_r[1];
              id_nxt.chip_count =
                4'(4'h1 << rbuf_r[2][`ID3_CHIPS_LSB +: 2]);
              id_nxt.cell_levels =
                5'(5'h02 << rbuf_r[2][`ID3_CELL_LSB +: 2]);
              id_nxt.page_kb =
                4'(4'h1 << rbuf_r[3][`ID4_PAGE_LSB +: 2]);
              id_nxt.block_kb =
                10'(10'h040 << rbuf_r[3][`ID4_BLOCK_LSB +: 2]);
              id_nxt.x16 = rbuf_r[3][`ID4_WIDTH_BIT];
              id_nxt.districts =
                4'(4'h1 << rbuf_r[4][`ID5_DIST_LSB +: 2]);
            end
          end
        endcase
      ST_LOW:
        if (cnt_r != 8'h00) cnt_nxt = cnt_r - 8'h01;
        else if (!rd_r)
        begin
          we_n_nxt = 1'b1;
          cnt_nxt = WE_HI - 8'h01;
          state_nxt = ST_HIGH;
        end
        else if (dq_s2_r == dq_s3_r)
        begin
          if (ridx_r < 3'(`ID_LEN)) rbuf_nxt[ridx_r] = dq_s3_r;
          ridx_nxt = ridx_r + 3'h1;
          re_n_nxt = 1'b1;
          cnt_nxt = RE_HI - 8'h01;
          state_nxt = ST_HIGH;
        end
      ST_HIGH:
        if (cnt_r != 8'h00) cnt_nxt = cnt_r - 8'h01;
        else
        begin
          cle_nxt = 1'b0;
          ale_nxt = 1'b0;
          dq_oe_nxt = 1'b0;
          step_nxt = step_r + 4'h1;
          state_nxt = ST_ISSUE;
        end
      ST_WAITB:
        if (cnt_r != 8'h00) cnt_nxt = cnt_r - 8'h01;
        else state_nxt = ST_WAITR;
      ST_WAITR:
        if (rdy_r)
        begin
          step_nxt = step_r + 4'h1;
          state_nxt = ST_ISSUE;
        end
      default: state_nxt = ST_IDLE;
    endcase
    cmd_ready_nxt = (state_nxt == ST_IDLE);
  end

  always_ff @(posedge sys_clk_i)
  begin
    dq_s1_r <= dq_i;
    dq_s2_r <= dq_s1_r;
    dq_s3_r <= dq_s2_r;
    rbuf_r <= rbuf_nxt;
    op_r <= op_nxt;
    ra_r <= ra_nxt;
    rb_r <= rb_nxt;
    dq_o <= dq_nxt;
    if (sys_rst_i)
    begin
      state_r <= ST_IDLE;    step_r <= 4'h0;     cnt_r <= 8'h00;
      rd_r <= 1'b0;          ridx_r <= 3'h0;     rb_s_r <= 3'h0;
      rdy_r <= 1'b0;         init_r <= 1'b0;     pe_r <= 1'b0;
      cmd_ready_o <= 1'b1;   done_o <= 1'b0;     refused_o <= 1'b0;
      status_o <= '0;        id_o <= '0;         ce_n_o <= 1'b1;
      cle_o <= 1'b0;         ale_o <= 1'b0;      we_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      wp_n_o <= 1'b0;        dq_oe_o <= 1'b0;    device_ready_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;  step_r <= step_nxt; cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;        ridx_r <= ridx_nxt; rb_s_r <= rb_s_nxt;
      rdy_r <= rdy_nxt;      init_r <= init_nxt; pe_r <= pe_nxt;
      cmd_ready_o <= cmd_ready_nxt;
      done_o <= done_nxt;    refused_o <= refused_nxt;
      status_o <= status_nxt;
      id_o <= id_nxt;        ce_n_o <= ce_n_nxt;
      cle_o <= cle_nxt;      ale_o <= ale_nxt;   we_n_o <= we_n_nxt;
      read_strobe_n_o <= re_n_nxt;
      wp_n_o <= wp_n_nxt;    dq_oe_o <= dq_oe_nxt;
      device_ready_o <= rdy_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: verification/nand_dev_model.sv */
/*
  Behavioural NAND device: status, district status, identification,
  block erase, reset and a busy time after power-on.
  Assumes the bench resolves the data bus and feeds the wire to dq_i.
*/
`default_nettype none

module nand_dev_model #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_ID   = 8'hC4, // arbitrary value
  parameter int         INIT_NS  = 400,
  parameter int         BUSY_NS  = 2000
) (
  input  wire logic       ce_n_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       we_n_i,
  input  wire logic       re_n_i,
  input  wire logic       wp_n_i,
  input  wire logic [7:0] dq_i,
  input  wire logic       fail_i,
  output logic      [7:0] dq_o,
  output logic            rb_n_o,
  output int              viol_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] id_b [5];
  logic [7:0] last  = 8'h00;
  logic [1:0] mode  = 2'd0;
  logic [1:0] dmask = 2'b00;
  logic [1:0] dfail = 2'b00;
  logic       fcur  = 1'b0;
  int         idx   = 0;
  int         acnt  = 3;
  task automatic busy(input int d);
    rb_n_o = 1'b0;
    fork
      #(d) rb_n_o = 1'b1;
    join_none
  endtask
  initial
  begin
    id_b = '{MAKER_ID, DEV_ID, 8'h91, 8'h26, 8'h76};
    viol_o = 0;
    busy(INIT_NS);
  end
  always @(posedge we_n_i)
  begin
    if (!ce_n_i && cle_i)
    begin
      if (!rb_n_o && !(dq_i inside {8'h70, 8'h71, 8'hFF}))
        viol_o++;
      if (!(dq_i inside {8'h60, 8'hD0, 8'h70, 8'h71, 8'h90, 8'hFF}))
        viol_o++;
      case (dq_i)
        8'h70: mode = 2'd1;
        8'h71: mode = 2'd2;
        8'h90:
        begin
          mode = 2'd3;
          idx = 0;
          acnt = 3;
        end
        8'h60: acnt = 0;
        8'hD0:
        begin
          if (dmask == 2'b00)
            viol_o++;
          dfail = (dfail & ~dmask) | (dmask & {2{fail_i}});
          fcur = fail_i;
          dmask = 2'b00;
          busy(BUSY_NS);
        end
        8'hFF:
        begin
          dmask = 2'b00;
          busy(BUSY_NS / 10);
        end
        default: mode = mode;
      endcase
    end
    if (!ce_n_i && ale_i)
    begin
      if (acnt == 0)
      begin
        if (dmask[dq_i[6]])
          viol_o++;
        dmask[dq_i[6]] = 1'b1;
      end
      acnt++;
    end
  end
  always @(negedge re_n_i)
  begin
    if (!ce_n_i)
    begin
      case (mode)
        2'd1: last = {wp_n_i, rb_n_o, rb_n_o, 4'h0, fcur};
        2'd2: last = {wp_n_i, rb_n_o, rb_n_o, 2'b00, dfail, |dfail};
        2'd3: last = id_b[idx % 5];
        default: last = ~last;
      endcase
      idx++;
    end
  end
  // a released bus shows the inverse, so stale data can never pass
  assign dq_o = (!ce_n_i && !re_n_i) ? last : ~last;
endmodule

`default_nettype wire

/* File: verification/nand_status_id_reset_control_asserts.sv */
/*
  Port checks of the NAND host controller: order refusals and strobes.
  Assumes one clock domain with a synchronous active-high reset.
*/
`default_nettype none

module nand_status_id_reset_control_asserts
  import nand_ctrl_pkg::*;
#(
  parameter int ROW_W = 18
) (
  input wire logic             sys_clk_i,
  input wire logic             sys_rst_i,
  input wire logic             cmd_valid_i,
  input wire op_type           cmd_op_i,
  input wire logic [ROW_W-1:0] row_a_i,
  input wire logic [ROW_W-1:0] row_b_i,
  input wire logic             cmd_ready_o,
  input wire logic             done_o,
  input wire logic             refused_o,
  input wire logic             device_ready_o,
  input wire logic             ce_n_o,
  input wire logic             cle_o,
  input wire logic             ale_o,
  input wire logic             we_n_o,
  input wire logic             read_strobe_n_o,
  input wire logic [7:0]       dq_o,
  input wire logic             dq_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic take = cmd_ready_o && cmd_valid_i;
  property p_bad_op;
    take && cmd_op_i > OP_MERASE |=> done_o && refused_o;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("bad op taken");
  property p_id_wait;
    take && cmd_op_i == OP_ID && !device_ready_o |=> refused_o;
  endproperty
  a_id_wait: assert property (p_id_wait) else $error("early id");
  property p_status_ok;
    take && cmd_op_i == OP_STATUS |=> !cmd_ready_o && !done_o;
  endproperty
  a_status_ok: assert property (p_status_ok) else $error("no st");
  property p_same_dist;
    take && cmd_op_i == OP_MERASE && row_a_i[6] == row_b_i[6] |=> refused_o;
  endproperty
  a_same_dist: assert property (p_same_dist) else $error("dist");
  property p_refuse_done;
    refused_o |-> done_o && cmd_ready_o;
  endproperty
  a_refuse_done: assert property (p_refuse_done) else $error("rf");
  property p_we_pulse;
    $fell(we_n_o) |-> !we_n_o [*3] ##1 we_n_o [*3];
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("we len");
  property p_we_qual;
    !we_n_o |-> (cle_o ^ ale_o) && dq_oe_o && !ce_n_o;
  endproperty
  a_we_qual: assert property (p_we_qual) else $error("we qual");
  property p_we_hold;
    $rose(we_n_o) |-> $stable(dq_o) && $stable(cle_o) && $stable(ale_o);
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("we hold");
  property p_re_pulse;
    $fell(read_strobe_n_o) |-> (!read_strobe_n_o && !dq_oe_o) [*5];
  endproperty
  a_re_pulse: assert property (p_re_pulse) else $error("re");
endmodule

bind nand_status_id_reset_control nand_status_id_reset_control_asserts
  #(.ROW_W(ROW_W)) chk_i (.sys_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_op_i,
  .row_a_i, .row_b_i, .cmd_ready_o, .done_o, .refused_o, .device_ready_o,
  .ce_n_o, .cle_o, .ale_o, .we_n_o, .read_strobe_n_o, .dq_o, .dq_oe_o);

`default_nettype wire

/* File: verification/nand_status_id_reset_control_tb.sv */
/*
  Self-checking bench: the controller drives the device model.
  Assumes the checker file binds itself to the design.
*/
`default_nettype none

module nand_status_id_reset_control_tb
  import nand_ctrl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER_ID = 8'h3C; // arbitrary value
  localparam logic [7:0] DEV_ID   = 8'hA7; // arbitrary value
  logic            sys_clk_i = 1'b0, sys_rst_i = 1'b1, cmd_valid_i = 1'b0;
  op_type          cmd_op_i = OP_RESET;
  logic [17:0]     row_a_i = '0, row_b_i = '0, ra, rb;
  logic            erase_enable_i = 1'b1, fail_set = 1'b0, rb_n, rf;
  logic            cmd_ready_o, done_o, refused_o, device_ready_o, dq_oe_o;
  logic            ce_n_o, cle_o, ale_o, we_n_o, read_strobe_n_o, wp_n_o;
  status_info_type status_o;
  id_info_type     id_o;
  logic [7:0]      dq_o, dev_dq, bus;
  int              fails = 0, compares = 0, viol, seed = 98;
  always #2 sys_clk_i = ~sys_clk_i;
  assign bus = dq_oe_o ? dq_o : dev_dq;
  nand_status_id_reset_control nand_status_id_reset_control_i (
    .sys_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_op_i, .row_a_i, .row_b_i,
    .erase_enable_i, .cmd_ready_o, .done_o, .refused_o, .device_ready_o,
    .status_o, .id_o, .ce_n_o, .cle_o, .ale_o, .we_n_o, .read_strobe_n_o,
    .wp_n_o, .ready_busy_n_i(rb_n), .dq_i(bus), .dq_o, .dq_oe_o);
  nand_dev_model #(.MAKER_ID(MAKER_ID), .DEV_ID(DEV_ID)) nand_dev_model_i (
    .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o),
    .re_n_i(read_strobe_n_o), .wp_n_i(wp_n_o), .dq_i(bus),
    .fail_i(fail_set), .dq_o(dev_dq), .rb_n_o(rb_n), .viol_o(viol));
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic run(input op_type op, input logic [17:0] a, b);
    int n;
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    row_a_i = a;
    row_b_i = b;
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b0;
    for (n = 0; done_o !== 1'b1 && n < 4000; n++)
      @(negedge sys_clk_i);
    if (n >= 4000)
    begin
      fails++;
      $display("MISMATCH done expected 1 seen %b", done_o);
      print_verdict();
    end
    else
      rf = refused_o;
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    run(OP_ID, 18'h0, 18'h0);
    cmp("early id refused", 1'b1, rf);
    run(OP_DSTATUS, 18'h0, 18'h0);
    cmp("early dstatus refused", 1'b1, rf);
    run(OP_STATUS, 18'h0, 18'h0);
    cmp("busy status", 8'h80, status_o.raw);
    cmp("busy pf valid", 1'b0, status_o.pass_fail_valid);
    run(OP_RESET, 18'h0, 18'h0);
    cmp("reset refused", 1'b0, rf);
    cmp("device ready", 1'b1, device_ready_o);
    run(OP_ID, 18'h0, 18'h0);
    cmp("maker", MAKER_ID, id_o.maker);
    cmp("device", DEV_ID, id_o.device);
    cmp("chips", 16'(1 << (8'h91 & 3)), id_o.chip_count);
    cmp("levels", 16'(2 << ((8'h91 >> 2) & 3)), id_o.cell_levels);
    cmp("page kb", 16'(1 << (8'h26 & 3)), id_o.page_kb);
    cmp("block kb", 16'(64 << ((8'h26 >> 4) & 3)), id_o.block_kb);
    cmp("x16", 8'h26 >> 6 & 1, id_o.x16);
    cmp("districts", 16'(1 << ((8'h76 >> 2) & 3)), id_o.districts);
    for (int op = 6; op < 8; op++)
    begin
      run(op_type'(op), 18'h0, 18'h0);
      cmp("undefined op refused", 1'b1, rf);
    end
    fail_set = 1'b1;
    run(OP_ERASE, 18'($random(seed)), 18'h0);
    cmp("erase refused", 1'b0, rf);
    run(OP_STATUS, 18'h0, 18'h0);
    cmp("erase status", 8'hE1, status_o.raw);
    cmp("pass fail valid", 1'b1, status_o.pass_fail_valid);
    for (int k = 0; k < 2; k++)
    begin
      fail_set = 1'(k);
      ra = 18'($random(seed));
      rb = 18'($random(seed));
      ra[6] = 1'(k);
      rb[6] = ~ra[6];
      rb[17] = ra[17];
      run(OP_MERASE, ra, rb);
      cmp("merase refused", 1'b0, rf);
      run(OP_DSTATUS, 18'h0, 18'h0);
      cmp("dstatus", {3'b111, 2'b00, {3{fail_set}}}, status_o.raw);
      cmp("district fail", {2'b00, {2{fail_set}}}, status_o.district_fail);
    end
    rb[6] = ra[6];
    run(OP_MERASE, ra, rb);
    cmp("same district refused", 1'b1, rf);
    erase_enable_i = 1'b0;
    run(OP_STATUS, 18'h0, 18'h0);
    cmp("protected", 8'h61, status_o.raw);
    cmp("not protected", 1'b0, status_o.not_protected);
    cmp("fail cur", 1'b1, status_o.fail_cur);
    cmp("page ready", 1'b1, status_o.page_ready);
    cmp("ready mismatch", 1'b0, status_o.ready_mismatch);
    cmp("device violations", 16'h0, 16'(viol));
    print_verdict();
  end
endmodule

`default_nettype wire
